// ---- core/alu_condition_flags.sv ----
// condition-flag logic of an 8-bit alu with flag save and restore stack
// assumes decoder inputs on mclk, one apb slave for flag_status_reg access
//
// Behaviour
// - sign flag copies result msb when the instruction affects it
// - add sets carry on carry out of the msb
// - subtract and compare set carry on borrow
// - shifts load carry with the last bit shifted out
// - rotate sets carry when the last bit rotated is one
// - carry clears when no carry-setting condition holds
// - overflow set when signed arithmetic result does not fit 8 bits
// - zero flag set only for an all-zero result
// - flags not affected by an instruction keep their value
// - software reads and writes all four flags through flag_status_reg
// - calls and interrupts push flags; restoring return reloads them
// - flags are produced in the same cycle as the result
// - add with carry adds carry; subtract with borrow subtracts it
// - compare immediate sets flags like subtracting the constant
// - unsigned comparisons decode from carry and zero
// - signed comparisons decode from zero, sign and overflow
// - flag register holds sign 3, overflow 2, carry 1, zero 0
// - 8-bit datapath; subtraction adds the two's complement
// - shifts move zero to seven places, rotate right zero to seven
`timescale 1ns/1ps
module alu_condition_flags
  import alu_flags_pkg::*;
#(
  parameter int STACK_DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic exec_valid,
  input wire alu_op_t exec_op,
  input wire logic [DATA_W-1:0] exec_a,
  input wire logic [DATA_W-1:0] exec_b,
  input wire logic [CNT_W-1:0] exec_cnt,
  input wire logic [FLAG_W-1:0] exec_flag_en,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic restore_flags,
  output logic [DATA_W-1:0] result_r,
  output logic result_we_r,
  output logic result_valid_r,
  output logic [FLAG_W-1:0] flags_r,
  output logic [COND_W-1:0] cond_out
);

  localparam int SAW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam int SCW = $clog2(STACK_DEPTH + 1);
  localparam logic [SAW-1:0] PTR_LAST = SAW'(STACK_DEPTH - 1);
  localparam logic [SCW-1:0] CNT_FULL = SCW'(STACK_DEPTH);

  // ripple-free add: returns {carry out, overflow, sum}
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [7:0] lo;
    logic [1:0] hi;
    lo = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    hi = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, lo[7]};
    return {hi[1], hi[1] ^ lo[7], hi[0], lo[6:0]};
  endfunction

  // circular stack pointer step, usable for any depth
  function automatic logic [SAW-1:0] ptr_inc(input logic [SAW-1:0] p);
    return (p == PTR_LAST) ? '0 : SAW'(p + 1'b1);
  endfunction
  function automatic logic [SAW-1:0] ptr_dec(input logic [SAW-1:0] p);
    return (p == '0) ? PTR_LAST : SAW'(p - 1'b1);
  endfunction

  logic [7:0] res_nxt, b_eff, shl_v;
  logic carry_nxt, ovf_nxt, cin, is_sub, store_res;
  logic [FLAG_W-1:0] calc_flags, flags_nxt, top_q;
  logic [9:0] sum;
  logic [15:0] rot;
  logic [2:0] left_idx, right_idx;
  logic [SAW-1:0] sp_r, sp_nxt;
  logic [SCW-1:0] depth_r;
  logic push_take, pop_take, restore_take, exec_take;
  logic apb_setup, apb_wr, apb_hit;
  logic [31:0] rd_mux;

  // operand conditioning: subtraction inverts the subtrahend, cin forms the
  // two's complement, and subtract with borrow drops cin when carry is set
  always_comb begin
    is_sub = (exec_op == OP_SUB) || (exec_op == OP_SBC) || (exec_op == OP_CMPI);
    b_eff = is_sub ? ~exec_b : exec_b;
    unique case (exec_op)
      OP_ADC: cin = flags_r[FLAG_C];
      OP_SBC: cin = ~flags_r[FLAG_C];
      OP_SUB, OP_CMPI: cin = 1'b1;
      default: cin = 1'b0;
    endcase
    sum = add8(exec_a, b_eff, cin);
  end

  // result and carry/overflow in one combinational pass so flags land with
  // the result; no extra state is spent on flag generation
  always_comb begin
    rot = {exec_a, exec_a} >> exec_cnt;
    shl_v = exec_a << exec_cnt;
    left_idx = 3'(4'd8 - {1'b0, exec_cnt}); // wraps to 0 at cnt 0, gated below
    right_idx = exec_cnt - 3'd1;
    res_nxt = sum[7:0];
    carry_nxt = 1'b0;
    ovf_nxt = 1'b0;
    store_res = 1'b1;
    unique case (exec_op)
      OP_ADD, OP_ADC: begin
        carry_nxt = sum[9];
        ovf_nxt = sum[8];
      end
      OP_SUB, OP_SBC, OP_CMPI: begin
        carry_nxt = ~sum[9];
        ovf_nxt = sum[8];
        store_res = (exec_op != OP_CMPI);
      end
      OP_AND: res_nxt = exec_a & exec_b;
      OP_OR: res_nxt = exec_a | exec_b;
      OP_XOR: res_nxt = exec_a ^ exec_b;
      OP_NOT: res_nxt = ~exec_a;
      OP_SHL: begin
        res_nxt = shl_v;
        carry_nxt = (exec_cnt != 3'd0) && exec_a[left_idx];
      end
      OP_SHR: begin
        res_nxt = exec_a >> exec_cnt;
        carry_nxt = (exec_cnt != 3'd0) && exec_a[right_idx];
      end
      OP_ROR: begin
        res_nxt = rot[7:0];
        carry_nxt = (exec_cnt != 3'd0) && exec_a[right_idx];
      end
      default: begin
        res_nxt = exec_a;
        store_res = 1'b0;
      end
    endcase
    calc_flags[FLAG_N] = res_nxt[7];
    calc_flags[FLAG_V] = ovf_nxt;
    calc_flags[FLAG_C] = carry_nxt;
    calc_flags[FLAG_Z] = (res_nxt == 8'h00);
  end

  // stack arbitration: a pop wins over a push in the same cycle, and a pop
  // on an empty stack is dropped rather than restoring stale flags
  assign pop_take = pop_req && (depth_r != '0);
  assign push_take = push_req && !pop_req;
  assign restore_take = pop_take && restore_flags;
  assign exec_take = exec_valid && !restore_take;
  assign sp_nxt = pop_take ? ptr_dec(sp_r) : (push_take ? ptr_inc(sp_r) : sp_r);

  // apb decode; zero wait states, so the answer comes in the access phase
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && (paddr == OFS_FLAGS);
  assign apb_hit = (paddr == OFS_FLAGS) || (paddr == OFS_COND) ||
                   (paddr == OFS_STACK) || (paddr == OFS_RESULT);
  assign pready = 1'b1;

  // flag next value: restore, then instruction, then software write
  always_comb begin
    flags_nxt = flags_r;
    if (restore_take) begin
      flags_nxt = top_q;
    end else if (exec_take) begin
      flags_nxt = (flags_r & ~exec_flag_en) | (calc_flags & exec_flag_en);
    end else if (apb_wr) begin
      flags_nxt = pwdata[FLAG_W-1:0];
    end
  end

  // flag register
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // result register, updated on the same edge as the flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      result_r <= RESULT_RST;
      result_we_r <= 1'b0;
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= exec_take;
      result_we_r <= exec_take && store_res;
      if (exec_take) begin
        result_r <= res_nxt;
      end
    end
  end

  // stack pointer and depth; a push past full wraps and overwrites the oldest
  always_ff @(posedge mclk) begin
    if (rst) begin
      sp_r <= '0;
      depth_r <= '0;
    end else begin
      sp_r <= sp_nxt;
      if (pop_take) begin
        depth_r <= SCW'(depth_r - 1'b1);
      end else if (push_take && (depth_r != CNT_FULL)) begin
        depth_r <= SCW'(depth_r + 1'b1);
      end
    end
  end

  // saved flag sets; top_q always shows the entry below the next pointer
  flag_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(FLAG_W),
    .AW(SAW)
  ) u_stack (
    .mclk(mclk),
    .wr_en(push_take),
    .wr_addr(sp_r),
    .wr_data(flags_r),
    .rd_addr(ptr_dec(sp_nxt)),
    .rd_data(top_q)
  );

  // comparison decode straight from the flag flops
  always_comb begin
    cond_out[COND_ULT] = flags_r[FLAG_C];
    cond_out[COND_ULE] = flags_r[FLAG_C] | flags_r[FLAG_Z];
    cond_out[COND_EQ] = flags_r[FLAG_Z];
    cond_out[COND_UGE] = ~flags_r[FLAG_C];
    cond_out[COND_UGT] = ~flags_r[FLAG_C] & ~flags_r[FLAG_Z];
    cond_out[COND_SLT] = flags_r[FLAG_N] ^ flags_r[FLAG_V];
    cond_out[COND_SLE] = flags_r[FLAG_Z] | (flags_r[FLAG_N] ^ flags_r[FLAG_V]);
    cond_out[COND_SGE] = ~(flags_r[FLAG_N] ^ flags_r[FLAG_V]);
    cond_out[COND_SGT] = ~flags_r[FLAG_Z] & ~(flags_r[FLAG_N] ^ flags_r[FLAG_V]);
  end

  // read mux; upper bits read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_FLAGS: rd_mux = {28'h0000000, flags_r};
      OFS_COND: rd_mux = {23'h000000, cond_out};
      OFS_STACK: rd_mux = 32'(depth_r);
      OFS_RESULT: rd_mux = {24'h000000, result_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data and error are captured in the setup cycle, so they come from
  // flops; the captured flags are those seen at setup, not at access
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= PRDATA_RST;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? PRDATA_RST : rd_mux;
      pslverr <= !apb_hit;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence push_s;
    push_take;
  endsequence
  sequence quiet_s;
    !push_req && !pop_req;
  endsequence
  property restore_p;
    logic [FLAG_W-1:0] f;
    (push_s, f = flags_r) ##1 quiet_s ##1 (pop_req && restore_flags) |=> (flags_r == f);
  endproperty

  sign_flag_a: assert property (exec_take && exec_flag_en[FLAG_N] |=>
    flags_r[FLAG_N] == result_r[7]) else $error("sign flag does not match result msb");

  add_carry_a: assert property (exec_take && exec_op == OP_ADD && exec_flag_en[FLAG_C] |=>
    flags_r[FLAG_C] == (({1'b0, $past(exec_a)} + {1'b0, $past(exec_b)}) > 9'h0ff))
    else $error("add carry wrong");

  sub_borrow_a: assert property (exec_take && is_sub && exec_op != OP_SBC &&
    exec_flag_en[FLAG_C] |=> flags_r[FLAG_C] == ($past(exec_a) < $past(exec_b)))
    else $error("borrow wrong");

  shift_carry_a: assert property (exec_take && exec_op == OP_SHR && exec_cnt != 3'd0 &&
    exec_flag_en[FLAG_C] |=> flags_r[FLAG_C] ==
    ((($past(exec_a) >> 3'($past(exec_cnt) - 3'd1)) & 8'h01) != 8'h00))
    else $error("shift carry wrong");

  rotate_carry_a: assert property (exec_take && exec_op == OP_ROR && exec_cnt != 3'd0 &&
    exec_flag_en[FLAG_C] |=> flags_r[FLAG_C] == result_r[7]) else $error("rotate carry wrong");

  logic_carry_a: assert property (exec_take && exec_flag_en[FLAG_C] &&
    (exec_op inside {OP_AND, OP_OR, OP_XOR, OP_NOT}) |=> !flags_r[FLAG_C])
    else $error("carry not cleared");

  add_ovf_a: assert property (exec_take && exec_op == OP_ADD && exec_flag_en[FLAG_V] |=>
    flags_r[FLAG_V] == ($signed({$past(exec_a[7]), $past(exec_a)}) +
    $signed({$past(exec_b[7]), $past(exec_b)}) > 9'sd127 ||
    $signed({$past(exec_a[7]), $past(exec_a)}) +
    $signed({$past(exec_b[7]), $past(exec_b)}) < -9'sd128)) else $error("overflow wrong");

  zero_flag_a: assert property (exec_take && exec_flag_en[FLAG_Z] |=>
    flags_r[FLAG_Z] == (result_r == 8'h00)) else $error("zero flag wrong");

  keep_flags_a: assert property (exec_take |=>
    ((flags_r ^ $past(flags_r)) & ~$past(exec_flag_en)) == 4'h0) else $error("unaffected flags moved");

  apb_flags_a: assert property (apb_wr && !exec_valid && !restore_take |=>
    flags_r == $past(pwdata[3:0])) else $error("flag write lost");

  stack_restore_a: assert property (restore_p) else $error("restored flags differ");

  same_cycle_a: assert property (exec_take |=> result_valid_r &&
    flags_r == (($past(flags_r) & ~$past(exec_flag_en)) | $past(calc_flags & exec_flag_en)))
    else $error("flags late");

  adc_sum_a: assert property (exec_take && exec_op == OP_ADC |=> result_r ==
    8'($past(exec_a) + $past(exec_b) + {7'h00, $past(flags_r[FLAG_C])})) else $error("adc sum");

  cmp_unsigned_a: assert property (exec_take && exec_op == OP_CMPI && exec_flag_en == 4'hf |=>
    cond_out[COND_ULT] == ($past(exec_a) < $past(exec_b)) &&
    cond_out[COND_UGT] == ($past(exec_a) > $past(exec_b)) && !result_we_r)
    else $error("unsigned compare wrong");

  cmp_signed_a: assert property (exec_take && exec_op == OP_CMPI && exec_flag_en == 4'hf |=>
    cond_out[COND_SLT] == ($signed($past(exec_a)) < $signed($past(exec_b))) &&
    cond_out[COND_SGT] == ($signed($past(exec_a)) > $signed($past(exec_b))))
    else $error("signed compare wrong");

endmodule // alu_condition_flags

// ---- core/alu_flags_pkg.sv ----
// constants and types for the alu condition-flag block
// assumes a 32-bit apb slave port and an 8-bit datapath on one clock
package alu_flags_pkg;

  // datapath and flag widths
  localparam int DATA_W = 8;
  localparam int FLAG_W = 4;
  localparam int CNT_W = 3;

  // flag positions inside flag_status_reg
  localparam int FLAG_N = 3;
  localparam int FLAG_V = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_Z = 0;

  // register byte offsets
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] OFS_FLAGS = 12'h000;
  localparam logic [11:0] OFS_COND = 12'h004;
  localparam logic [11:0] OFS_STACK = 12'h008;
  localparam logic [11:0] OFS_RESULT = 12'h00c;

  // condition bits of the comparison register
  localparam int COND_W = 9;
  localparam int COND_ULT = 0;
  localparam int COND_ULE = 1;
  localparam int COND_EQ = 2;
  localparam int COND_UGE = 3;
  localparam int COND_UGT = 4;
  localparam int COND_SLT = 5;
  localparam int COND_SLE = 6;
  localparam int COND_SGE = 7;
  localparam int COND_SGT = 8;

  // values after reset
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [31:0] PRDATA_RST = 32'h0000_0000;

  // operation codes presented by the instruction decoder
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_ADC = 4'h1,
    OP_SUB = 4'h2,
    OP_SBC = 4'h3,
    OP_CMPI = 4'h4,
    OP_AND = 4'h5,
    OP_OR = 4'h6,
    OP_XOR = 4'h7,
    OP_NOT = 4'h8,
    OP_SHL = 4'h9,
    OP_SHR = 4'ha,
    OP_ROR = 4'hb
  } alu_op_t;

endpackage

// ---- core/flag_stack_mem.sv ----
// small memory holding saved flag sets for the address stack
// assumes pointers are managed by the caller; read data is registered, write-first
`timescale 1ns/1ps
module flag_stack_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 4,
  parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // storage array; no reset so it maps onto plain ram
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read; a write to the same slot is passed straight through
  always_ff @(posedge mclk) begin
    if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // flag_stack_mem

// ---- bench/alu_condition_flags_tb_top.sv ----
// self-checking bench for the alu condition-flag block
// assumes the package is compiled first; the bench is apb master and decoder
`timescale 1ns/1ps
module alu_condition_flags_tb_top;
  import alu_flags_pkg::*;

  localparam int DEPTH = 4;
  // op, operand a, operand b, count
  localparam logic [22:0] VEC [17] = '{
    {OP_ADD, 8'h80, 8'h80, 3'h0}, {OP_SUB, 8'h05, 8'h05, 3'h0},
    {OP_CMPI, 8'h03, 8'h05, 3'h0}, {OP_CMPI, 8'h80, 8'h01, 3'h0},
    {OP_AND, 8'hf0, 8'h0f, 3'h0}, {OP_OR, 8'ha0, 8'h05, 3'h0},
    {OP_XOR, 8'hff, 8'h0f, 3'h0}, {OP_NOT, 8'h5a, 8'h00, 3'h0},
    {OP_SHL, 8'h81, 8'h00, 3'h1}, {OP_SHL, 8'hc1, 8'h00, 3'h7},
    {OP_SHL, 8'hff, 8'h00, 3'h0}, {OP_SHR, 8'h81, 8'h00, 3'h1},
    {OP_SHR, 8'h80, 8'h00, 3'h7}, {OP_ROR, 8'h01, 8'h00, 3'h1},
    {OP_ROR, 8'h16, 8'h00, 3'h3}, {OP_ADC, 8'h7f, 8'h00, 3'h0},
    {OP_SBC, 8'h00, 8'h00, 3'h0}};
  // compare pairs x, y
  localparam logic [15:0] CMP [7] = '{16'h0305, 16'h0503, 16'h0505, 16'h8001,
    16'h7fff, 16'h0080, 16'hff00};

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic exec_valid = 1'b0;
  alu_op_t exec_op = OP_ADD;
  logic [DATA_W-1:0] exec_a = '0;
  logic [DATA_W-1:0] exec_b = '0;
  logic [CNT_W-1:0] exec_cnt = '0;
  logic [FLAG_W-1:0] exec_flag_en = '0;
  logic push_req = 1'b0;
  logic pop_req = 1'b0;
  logic restore_flags = 1'b0;
  logic [DATA_W-1:0] result_r;
  logic result_we_r;
  logic result_valid_r;
  logic [FLAG_W-1:0] flags_r;
  logic [COND_W-1:0] cond_out;
  int bad_count = 0;
  int checks = 0;
  logic [3:0] exp_f = 4'h0;
  logic [31:0] rd;
  logic err;

  // 125 MHz
  always #4 mclk = ~mclk;

  alu_condition_flags #(.STACK_DEPTH(DEPTH)) i_alu_condition_flags (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exec_valid(exec_valid), .exec_op(exec_op), .exec_a(exec_a),
    .exec_b(exec_b), .exec_cnt(exec_cnt), .exec_flag_en(exec_flag_en),
    .push_req(push_req), .pop_req(pop_req), .restore_flags(restore_flags),
    .result_r(result_r), .result_we_r(result_we_r), .result_valid_r(result_valid_r),
    .flags_r(flags_r), .cond_out(cond_out));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; the request is held until pready is seen at an edge, for at most 16 edges
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wflags(input logic [3:0] f);
    apb(1'b1, OFS_FLAGS, {28'h0, f});
    exp_f = f;
  endtask

  // independent reference: {result, n, v, c, z}
  function automatic logic [11:0] model(input alu_op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [2:0] k, input logic cf);
    logic [8:0] s;
    logic [7:0] r;
    logic c;
    logic v;
    c = 1'b0;
    v = 1'b0;
    r = a;
    s = 9'h000;
    case (op)
      OP_ADD, OP_ADC: begin
        s = {1'b0, a} + {1'b0, b} + ((op == OP_ADC) ? {8'h00, cf} : 9'h000);
        r = s[7:0];
        c = s[8];
        v = (a[7] == b[7]) && (r[7] != a[7]);
      end
      OP_SUB, OP_SBC, OP_CMPI: begin
        // bit 8 of the wrapped difference is the borrow
        s = {1'b0, a} - {1'b0, b} - ((op == OP_SBC) ? {8'h00, cf} : 9'h000);
        r = s[7:0];
        c = s[8];
        v = (a[7] != b[7]) && (r[7] != a[7]);
      end
      OP_AND: r = a & b;
      OP_OR: r = a | b;
      OP_XOR: r = a ^ b;
      OP_NOT: r = ~a;
      OP_SHL: begin
        r = a << k;
        c = (k != 3'h0) && a[8 - int'(k)];
      end
      OP_SHR: begin
        r = a >> k;
        c = (k != 3'h0) && a[int'(k) - 1];
      end
      OP_ROR: begin
        r = (a >> k) | (a << (8 - int'(k)));
        c = (k != 3'h0) && a[int'(k) - 1];
      end
      default: r = a;
    endcase
    return {r, r[7], v, c, r == 8'h00};
  endfunction

  // bits: sgt sge sle slt ugt uge eq ule ult
  function automatic logic [8:0] cond(input logic [3:0] f);
    return {~f[0] & (f[3] == f[2]), f[3] == f[2], f[0] | (f[3] != f[2]),
      f[3] != f[2], ~f[1] & ~f[0], ~f[1], f[0], f[1] | f[0], f[1]};
  endfunction

  // one instruction; everything is compared the cycle after it is taken
  task automatic exec(input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
      input logic [2:0] k, input logic [3:0] en);
    logic [11:0] m;
    m = model(op, a, b, k, exp_f[FLAG_C]);
    @(posedge mclk);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_a <= a;
    exec_b <= b;
    exec_cnt <= k;
    exec_flag_en <= en;
    @(posedge mclk);
    exec_valid <= 1'b0;
    exp_f = (m[3:0] & en) | (exp_f & ~en);
    #1;
    chk(flags_r, exp_f);
    chk(result_r, m[11:4]);
    chk(result_valid_r, 1'b1);
    chk(result_we_r, op != OP_CMPI);
    chk(cond_out, cond(exp_f));
  endtask

  task automatic stk(input logic pu, input logic po, input logic rf);
    @(posedge mclk);
    push_req <= pu;
    pop_req <= po;
    restore_flags <= rf;
    @(posedge mclk);
    push_req <= 1'b0;
    pop_req <= 1'b0;
    restore_flags <= 1'b0;
    #1;
  endtask

  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    results();
  end

  initial begin : main
    logic [7:0] x;
    logic [7:0] y;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk(flags_r, FLAGS_RST);
    chk(cond_out, 9'h198);
    // carry and overflow worked examples
    exec(OP_ADD, 8'hea, 8'h8c, 3'h0, 4'hf);
    chk(flags_r, 4'h6);
    exec(OP_SUB, 8'hba, 8'hc4, 3'h0, 4'hf);
    chk(flags_r, 4'ha);
    exec(OP_ADD, 8'hdc, 8'h63, 3'h0, 4'hf);
    chk(flags_r, 4'h2);
    for (int i = 0; i < 17; i++) begin
      exec(alu_op_t'(VEC[i][22:19]), VEC[i][18:11], VEC[i][10:3], VEC[i][2:0], 4'hf);
    end
    // only enabled flags move
    wflags(4'hf);
    exec(OP_ADD, 8'h01, 8'h01, 3'h0, 4'h1);
    chk(flags_r, 4'he);
    exec(OP_SUB, 8'h00, 8'h01, 3'h0, 4'h0);
    chk(flags_r, 4'he);
    // 16-bit chains through the carry
    exec(OP_ADD, 8'hff, 8'h01, 3'h0, 4'hf);
    exec(OP_ADC, 8'h01, 8'h00, 3'h0, 4'hf);
    chk(result_r, 8'h02);
    exec(OP_SUB, 8'h00, 8'h01, 3'h0, 4'hf);
    exec(OP_SBC, 8'h02, 8'h00, 3'h0, 4'hf);
    chk(result_r, 8'h01);
    apb(1'b0, OFS_RESULT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk(rd, {28'h0, exp_f});
    // compare decodes against the true relation of x and y
    for (int i = 0; i < 7; i++) begin
      x = CMP[i][15:8];
      y = CMP[i][7:0];
      exec(OP_CMPI, x, y, 3'h0, 4'hf);
      chk(cond_out, {$signed(x) > $signed(y), $signed(x) >= $signed(y),
        $signed(x) <= $signed(y), $signed(x) < $signed(y), x > y, x >= y, x == y,
        x <= y, x < y});
    end
    // every flag pattern through the flag register
    for (int f = 0; f < 16; f++) begin
      wflags(4'(f));
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd, 32'(f));
      apb(1'b0, OFS_COND, 32'h0);
      chk(rd, {23'h0, cond(4'(f))});
    end
    apb(1'b1, OFS_COND, 32'hffff_ffff);
    chk(flags_r, 4'hf);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // save and restore through the stack
    wflags(4'h5);
    stk(1'b1, 1'b0, 1'b0);
    wflags(4'ha);
    stk(1'b0, 1'b1, 1'b1);
    chk(flags_r, 4'h5);
    apb(1'b0, OFS_STACK, 32'h0);
    chk(rd, 32'h0);
    stk(1'b0, 1'b1, 1'b1);
    chk(flags_r, 4'h5);
    stk(1'b1, 1'b0, 1'b0);
    wflags(4'hc);
    stk(1'b0, 1'b1, 1'b0);
    chk(flags_r, 4'hc);
    // push, one quiet cycle, restoring pop: the spacing the stack assertion watches
    stk(1'b1, 1'b0, 1'b0);
    stk(1'b0, 1'b1, 1'b1);
    chk(flags_r, 4'hc);
    repeat (DEPTH + 1) stk(1'b1, 1'b0, 1'b0);
    apb(1'b0, OFS_STACK, 32'h0);
    chk(rd, 32'(DEPTH));
    results();
  end
endmodule // alu_condition_flags_tb_top
